// *** logic/rlb_rom.sv ***
// Behaviour
// - the memory is read-only; nothing, including the bus, can change a stored word.
// - the incoming address is captured in a register and that register drives the read.
// - an optional output register adds one clock of latency, else data comes straight from the read.
// - the clock enable never gates the output register, which updates every clock.
// - the clock enable is honoured only when the enable option is built in.
// - the depth in words is a build parameter; valid addresses are zero to depth minus one.
// - the word format is signed integer, signed fractional or unsigned integer.
// - for the signed formats the output msb is the two's complement sign bit.
// - contents are fixed at build time from a hex record image or an initialization vector.
// - the hex image may use extended linear address records for 32-bit addressing.
// - a binary phase string selects the enabled clock phases, a one marking each.
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
module rlb_rom
    import rlb_pkg::*;
#(
    parameter int AW = 8,
    parameter int DEPTH = 256,
    parameter rlb_fmt_t FMT = RLB_FMT_UINT,
    parameter int INT_W = 8,
    parameter int FRAC_W = 0,
    parameter bit REG_OUT = 1'b1,
    parameter bit USE_ENA = 1'b1,
    parameter rlb_init_t INIT_SRC = RLB_INIT_VEC,
    parameter int VEC_LEN = 1,
    parameter logic [VEC_LEN*32-1:0] INIT_VEC = '0,
    parameter int HEX_NREC = 1,
    parameter logic [HEX_NREC*64-1:0] HEX_REC = RLB_REC_EOF_ONLY,
    parameter int PHASE_LEN = 1,
    parameter logic [PHASE_LEN-1:0] PHASE_MASK = '1,
    localparam int DW = (FMT == RLB_FMT_SFRAC) ? INT_W + FRAC_W : INT_W,
    localparam int PW = (PHASE_LEN > 1) ? $clog2(PHASE_LEN) : 1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    // datapath side
    input wire logic [AW-1:0] rom_addr,
    input wire logic ena,
    output logic [DW-1:0] rom_data,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ************************************************
    // storage
    // ************************************************
    // no write port
    logic [DW-1:0] mem [DEPTH];

    // build-time contents, everything else stays zero
    // pick the content source
    initial begin
        logic [15:0] ela;
        logic [63:0] rec;
        logic [31:0] wa;
        bit done;
        ela = '0;
        rec = '0;
        wa = '0;
        done = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = '0;
        end
        if (INIT_SRC == RLB_INIT_VEC) begin
            for (int i = 0; i < VEC_LEN && i < DEPTH; i++) begin
                mem[i] = INIT_VEC[i*RLB_VEC_ELEM_W +: DW];
            end
        end else begin
            for (int r = 0; r < HEX_NREC; r++) begin
                rec = HEX_REC[r*RLB_REC_W +: RLB_REC_W];
                if (!done) begin
                    case (rec[RLB_REC_TYPE_LSB +: 8])
                        RLB_REC_ELA: begin
                            ela = rec[15:0];
                        end
                        RLB_REC_DATA: begin
                            wa = {ela, rec[RLB_REC_OFS_LSB +: 16]};
                            if (wa < 32'(DEPTH)) begin
                                mem[wa] = rec[DW-1:0];
                            end
                        end
                        RLB_REC_EOF: begin
                            done = 1'b1;
                        end
                        default: begin
                            done = done;
                        end
                    endcase
                end
            end
        end
    end

    // ************************************************
    // phase selection
    // ************************************************
    wire logic phase_hit;
    wire logic [PW-1:0] phase_idx;

    rlb_phase_gen #(
        .PHASE_LEN(PHASE_LEN),
        .PHASE_MASK(PHASE_MASK)
    ) u_phase (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .phase_hit(phase_hit),
        .phase_idx(phase_idx)
    );

    // ************************************************
    // address capture and read
    // ************************************************
    logic [AW-1:0] addr_ff;
    logic [31:0] ctrl_ff;
    wire logic ena_eff;
    wire logic cap_en;
    wire logic addr_ok;
    wire logic [DW-1:0] rd_word;

    assign ena_eff = USE_ENA ? ena : 1'b1;
    assign cap_en = ena_eff & phase_hit & ctrl_ff[RLB_CTRL_RUN_BIT];

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            addr_ff <= '0;
        end else if (cap_en) begin
            addr_ff <= rom_addr;
        end
    end

    assign addr_ok = (32'(addr_ff) < 32'(DEPTH));
    // in the signed formats the word is stored two's complement, msb is sign
    assign rd_word = addr_ok ? mem[addr_ok ? addr_ff : '0] : '0;

    generate
        if (REG_OUT) begin : g_reg_out
            logic [DW-1:0] q_ff;
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    q_ff <= '0;
                end else begin
                    q_ff <= rd_word;
                end
            end
            assign rom_data = q_ff;
        end else begin : g_comb_out
            assign rom_data = rd_word;
        end
    endgenerate

    // ************************************************
    // bus write channel
    // ************************************************
    logic aw_held_ff;
    logic w_held_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic awready_ff;
    logic wready_ff;
    logic [AW-1:0] peek_ff;
    wire logic aw_take;
    wire logic w_take;
    wire logic aw_have;
    wire logic w_have;
    wire logic [7:0] wr_addr;
    wire logic [31:0] wr_data;
    wire logic [3:0] wr_strb;
    wire logic wr_go;
    wire logic wr_ctrl;
    wire logic wr_peek;
    wire logic wr_ro;
    wire logic b_done;
    wire logic nxt_aw_held;
    wire logic nxt_w_held;
    wire logic nxt_bvalid;
    wire logic [31:0] strb_mask;
    wire logic [1:0] nxt_bresp;

    assign aw_take = s_axi_awvalid & awready_ff;
    assign w_take = s_axi_wvalid & wready_ff;
    assign aw_have = aw_held_ff | aw_take;
    assign w_have = w_held_ff | w_take;
    assign wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
    assign wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
    assign wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;
    assign wr_go = aw_have & w_have & ~bvalid_ff;
    assign b_done = bvalid_ff & s_axi_bready;

    // write decode
    assign wr_ctrl = (wr_addr == RLB_OFS_CTRL);
    assign wr_peek = (wr_addr == RLB_OFS_PEEK_ADDR);
    // word, status and phase registers refuse writes
    assign wr_ro = (wr_addr == RLB_OFS_PEEK_DATA) | (wr_addr == RLB_OFS_ADDR_CUR)
                   | (wr_addr == RLB_OFS_PHASE);
    assign nxt_bresp = (wr_ctrl | wr_peek) ? RLB_RESP_OKAY
                     : wr_ro ? RLB_RESP_SLVERR : RLB_RESP_DECERR;
    assign strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

    assign nxt_aw_held = aw_have & ~wr_go;
    assign nxt_w_held = w_have & ~wr_go;
    assign nxt_bvalid = wr_go | (bvalid_ff & ~s_axi_bready);

    // address and data latches, response flag
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bresp_ff <= RLB_RESP_OKAY;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            bvalid_ff <= nxt_bvalid;
            awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
            wready_ff <= ~nxt_w_held & ~nxt_bvalid;
            bresp_ff <= wr_go ? nxt_bresp : b_done ? RLB_RESP_OKAY : bresp_ff; // okay again once answered
        end
    end

    // payload capture
    always_ff @(posedge clk_sys) begin
        if (aw_take) begin
            awaddr_ff <= s_axi_awaddr;
        end
        if (w_take) begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end
    end

    // control and peek address, byte-lane writes
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_ff <= RLB_CTRL_RST;
            peek_ff <= '0;
        end else if (wr_go && wr_ctrl) begin
            ctrl_ff <= (ctrl_ff & ~strb_mask) | (wr_data & strb_mask & RLB_CTRL_RST);
        end else if (wr_go && wr_peek) begin
            peek_ff <= AW'((32'(peek_ff) & ~strb_mask) | (wr_data & strb_mask));
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // ************************************************
    // bus read channel
    // ************************************************
    logic rvalid_ff;
    logic arready_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    wire logic ar_take;
    wire logic peek_ok;
    wire logic [DW-1:0] peek_word;
    wire logic [31:0] peek_ext;
    wire logic [31:0] nxt_rdata;
    wire logic [1:0] nxt_rresp;
    wire logic sign_fmt;

    assign ar_take = s_axi_arvalid & arready_ff;
    assign peek_ok = (32'(peek_ff) < 32'(DEPTH));
    assign peek_word = peek_ok ? mem[peek_ok ? peek_ff : '0] : '0;
    assign sign_fmt = (FMT != RLB_FMT_UINT);
    // sign extend signed formats onto the bus
    assign peek_ext = {{(32-DW){sign_fmt & peek_word[DW-1]}}, peek_word};

    // read decode
    assign nxt_rdata = (s_axi_araddr == RLB_OFS_CTRL) ? ctrl_ff
                     : (s_axi_araddr == RLB_OFS_ADDR_CUR) ? 32'(addr_ff)
                     : (s_axi_araddr == RLB_OFS_PEEK_ADDR) ? 32'(peek_ff)
                     : (s_axi_araddr == RLB_OFS_PEEK_DATA) ? peek_ext
                     : (s_axi_araddr == RLB_OFS_PHASE) ? 32'(phase_idx)
                     : 32'h0000_0000;
    assign nxt_rresp = ((s_axi_araddr == RLB_OFS_CTRL) | (s_axi_araddr == RLB_OFS_ADDR_CUR)
                       | (s_axi_araddr == RLB_OFS_PEEK_ADDR) | (s_axi_araddr == RLB_OFS_PEEK_DATA)
                       | (s_axi_araddr == RLB_OFS_PHASE)) ? RLB_RESP_OKAY : RLB_RESP_DECERR;

    // one read in flight
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RLB_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_ff <= 1'b1;
            arready_ff <= 1'b0;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end else if (!rvalid_ff) begin
            arready_ff <= 1'b1;
        end
    end

    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

endmodule : rlb_rom

// *** logic/rlb_pkg.sv ***
package rlb_pkg;

    // ************************************************
    // stored word formats, one-hot
    // ************************************************
    typedef enum logic [2:0] {
        RLB_FMT_SINT = 3'h1,
        RLB_FMT_SFRAC = 3'h2,
        RLB_FMT_UINT = 3'h4
    } rlb_fmt_t;

    // ************************************************
    // source of the build-time contents, one-hot
    // ************************************************
    typedef enum logic [1:0] {
        RLB_INIT_HEX = 2'h1,
        RLB_INIT_VEC = 2'h2
    } rlb_init_t;

    // ************************************************
    // hex record image: {pad8, type8, offset16, data32}
    // ************************************************
    localparam int RLB_REC_W = 64;
    localparam int RLB_REC_TYPE_LSB = 48;
    localparam int RLB_REC_OFS_LSB = 32;
    localparam logic [7:0] RLB_REC_DATA = 8'h00;
    localparam logic [7:0] RLB_REC_EOF = 8'h01;
    localparam logic [7:0] RLB_REC_ELA = 8'h04;
    localparam logic [63:0] RLB_REC_EOF_ONLY = 64'h0001_0000_0000_0000;
    localparam int RLB_VEC_ELEM_W = 32;

    // ************************************************
    // register map (byte addresses)
    // ************************************************
    localparam logic [7:0] RLB_OFS_CTRL = 8'h00;
    localparam logic [7:0] RLB_OFS_ADDR_CUR = 8'h04;
    localparam logic [7:0] RLB_OFS_PEEK_ADDR = 8'h08;
    localparam logic [7:0] RLB_OFS_PEEK_DATA = 8'h0C;
    localparam logic [7:0] RLB_OFS_PHASE = 8'h10;
    localparam int RLB_CTRL_RUN_BIT = 0;
    localparam logic [31:0] RLB_CTRL_RST = 32'h0000_0001;

    // ************************************************
    // axi4-lite responses
    // ************************************************
    localparam logic [1:0] RLB_RESP_OKAY = 2'h0;
    localparam logic [1:0] RLB_RESP_SLVERR = 2'h2;
    localparam logic [1:0] RLB_RESP_DECERR = 2'h3;

endpackage : rlb_pkg

// *** logic/rlb_phase_gen.sv ***
module rlb_phase_gen
    import rlb_pkg::*;
#(
    parameter int PHASE_LEN = 1,
    parameter logic [PHASE_LEN-1:0] PHASE_MASK = '1,
    localparam int CW = (PHASE_LEN > 1) ? $clog2(PHASE_LEN) : 1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    output logic phase_hit,
    output logic [CW-1:0] phase_idx
);

    // ************************************************
    // phase counter
    // ************************************************
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic hit_ff;
    wire logic cnt_wrap;

    // the counter runs on every clock, one phase per sample
    assign cnt_wrap = (cnt_ff == CW'(PHASE_LEN - 1));
    assign nxt_cnt = cnt_wrap ? '0 : cnt_ff + CW'(1);

    // leftmost string character is the first phase
    function automatic logic mask_at(input logic [CW-1:0] idx);
        mask_at = PHASE_MASK[PHASE_LEN - 1 - int'(idx)];
    endfunction : mask_at

    // counter and registered phase hit
    // phase string decode
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            hit_ff <= PHASE_MASK[PHASE_LEN-1];
        end else begin
            cnt_ff <= nxt_cnt;
            hit_ff <= mask_at(nxt_cnt);
        end
    end

    assign phase_hit = hit_ff;
    assign phase_idx = cnt_ff;

endmodule : rlb_phase_gen

// *** verification/rlb_src.sv ***
module rlb_src #(
    parameter int AW = 4
) (
    input wire logic clk_sys,
    input wire logic [AW-1:0] set_addr,
    input wire logic set_ena,
    output logic [AW-1:0] rom_addr = '0,
    output logic ena = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;

    always @(posedge clk_sys) begin
        rom_addr <= set_addr;
        ena <= set_ena;
    end
endmodule : rlb_src

// *** verification/rlb_rom_sva.sv ***
module rlb_rom_chk
    import rlb_pkg::*;
#(
    parameter int AW = 8,
    parameter int DW = 8,
    parameter int DEPTH = 256,
    parameter int VEC_LEN = 1,
    parameter logic [VEC_LEN*32-1:0] INIT_VEC = '0
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [AW-1:0] rom_addr,
    input wire logic ena,
    input wire logic [DW-1:0] rom_data,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // stored word at an address, zero past the vector or depth
    function automatic logic [DW-1:0] word(input logic [AW-1:0] a);
        return (int'(a) < VEC_LEN && int'(a) < DEPTH) ? INIT_VEC[int'(a)*32 +: DW] : '0;
    endfunction : word

    sequence s_addr_held;
        ena && $past(ena) && rom_addr == $past(rom_addr);
    endsequence
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    // address held over two enabled edges always meets a phase
    property p_word;
        logic [AW-1:0] a_v;
        (s_addr_held, a_v = rom_addr) |-> ##2 rom_data == word(a_v);
    endproperty

    a_read_word: assert property (p_word)
        else $error("rom_data differs from stored word");
    a_out_hold: assert property (!ena [*3] |=> $stable(rom_data))
        else $error("rom_data moved while enable low");
    a_write_answer: assert property (s_wr_taken |=> s_axi_bvalid)
        else $error("no write response after address and data");
    a_ro_write: assert property (s_wr_taken and s_axi_awaddr == RLB_OFS_ADDR_CUR |=> s_axi_bresp == RLB_RESP_SLVERR)
        else $error("write to read-only place not refused");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("no read data after read address");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_busy_ready: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write ready while response pending");
endmodule : rlb_rom_chk

bind rlb_rom rlb_rom_chk #(.AW(AW), .DW(DW), .DEPTH(DEPTH), .VEC_LEN(VEC_LEN), .INIT_VEC(INIT_VEC)) u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .rom_addr(rom_addr), .ena(ena), .rom_data(rom_data),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
);

// *** verification/rlb_rom_test.sv ***
module rlb_rom_test
    import rlb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [127:0] VEC = 128'h0000_0080_0000_007f_0000_0012_0000_00a5;
    localparam int TB_AW = 4;
    localparam int TB_PLEN = 2;
    localparam logic [1:0] TB_PMASK = 2'h2;
    logic clk_sys, rst_n, set_ena, ena;
    logic [3:0] set_addr, rom_addr;
    logic [7:0] rom_data, s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;

    rlb_src #(.AW(TB_AW)) u_src (.clk_sys(clk_sys), .set_addr(set_addr), .set_ena(set_ena),
        .rom_addr(rom_addr), .ena(ena));

    rlb_rom #(.AW(TB_AW), .DEPTH(12), .FMT(RLB_FMT_SINT), .INT_W(8), .VEC_LEN(4), .INIT_VEC(VEC),
        .PHASE_LEN(TB_PLEN), .PHASE_MASK(TB_PMASK)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .rom_addr(rom_addr), .ena(ena), .rom_data(rom_data),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    // ****
    // compares and verdict
    // ****
    task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk_word

    task automatic chk_resp(input string what, input logic [1:0] e, input logic [1:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk_resp

    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    // ****
    // access tasks
    // ****
    // present an address for two cycles with the given enable, then compare a word
    task automatic rom_look(input logic [3:0] a, input logic en, input int ea);
        @(posedge clk_sys);
        set_addr <= a;
        set_ena <= en;
        repeat (2) @(posedge clk_sys);
        set_ena <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 chk_word("rom_data", {24'h00_0000, (ea < 4) ? VEC[ea*32 +: 8] : 8'h00}, {24'h00_0000, rom_data});
    endtask : rom_look

    // present an address for one enabled edge on a chosen phase, then compare a word
    // phase 1 falls on odd edge counts; the source model adds one edge before the dut sees it
    task automatic rom_one(input logic [3:0] a, input logic hit, input int ea);
        do begin
            @(posedge clk_sys);
        end while (cycles[0] == hit);
        set_addr <= a;
        set_ena <= 1'b1;
        @(posedge clk_sys);
        set_ena <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 chk_word("rom_data", {24'h00_0000, (ea < 4) ? VEC[ea*32 +: 8] : 8'h00}, {24'h00_0000, rom_data});
    endtask : rom_one

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk_resp("bresp", er, s_axi_bresp);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk_word("rdata", ed, s_axi_rdata);
        chk_resp("rresp", er, s_axi_rresp);
    endtask : axi_read

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            conclude();
        end
    end

    initial begin
        {rst_n, set_ena, set_addr, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        rom_look(4'h1, 1'b1, 1);
        rom_look(4'h0, 1'b1, 0);
        rom_look(4'h4, 1'b1, 4);
        rom_look(4'hb, 1'b1, 11);
        rom_look(4'hf, 1'b1, 15);
        rom_look(4'h3, 1'b1, 3);
        rom_look(4'h2, 1'b0, 3);
        axi_read(RLB_OFS_CTRL, RLB_CTRL_RST, RLB_RESP_OKAY);
        axi_write(RLB_OFS_PEEK_ADDR, 32'h0000_0003, RLB_RESP_OKAY);
        axi_read(RLB_OFS_PEEK_DATA, 32'hffff_ff80, RLB_RESP_OKAY);
        axi_write(RLB_OFS_PEEK_ADDR, 32'h0000_0008, RLB_RESP_OKAY);
        axi_read(RLB_OFS_PEEK_DATA, 32'h0000_0000, RLB_RESP_OKAY);
        axi_write(RLB_OFS_PEEK_DATA, 32'h0000_0055, RLB_RESP_SLVERR);
        axi_read(RLB_OFS_PEEK_DATA, 32'h0000_0000, RLB_RESP_OKAY);
        axi_write(RLB_OFS_ADDR_CUR, 32'h0000_0002, RLB_RESP_SLVERR);
        axi_read(RLB_OFS_ADDR_CUR, 32'h0000_0003, RLB_RESP_OKAY);
        axi_write(8'h20, 32'h0000_0001, RLB_RESP_DECERR);
        axi_read(8'h20, 32'h0000_0000, RLB_RESP_DECERR);
        rom_look(4'h3, 1'b0, 3);
        rom_one(4'h2, 1'b1, 2);
        rom_one(4'h1, 1'b0, 2);
        axi_write(RLB_OFS_CTRL, 32'h0000_0000, RLB_RESP_OKAY);
        axi_read(RLB_OFS_CTRL, 32'h0000_0000, RLB_RESP_OKAY);
        rom_one(4'h1, 1'b1, 2);
        axi_write(RLB_OFS_CTRL, RLB_CTRL_RST, RLB_RESP_OKAY);
        axi_write(RLB_OFS_PHASE, 32'h0000_0001, RLB_RESP_SLVERR);
        s_axi_wstrb <= 4'he;
        axi_write(RLB_OFS_PEEK_ADDR, 32'h0000_0001, RLB_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        axi_read(RLB_OFS_PEEK_ADDR, 32'h0000_0008, RLB_RESP_OKAY);
        rom_look(4'h1, 1'b1, 1);
        conclude();
    end
endmodule : rlb_rom_test
